// file: bench/mml_mem_model.sv
// Memory-side model that answers data and flash reads of the access controller.
`timescale 1ns/10ps
`default_nettype none
module mml_mem_model (
   input wire logic i_core_clk,
   input wire logic i_mem_req,
   input wire logic [15:0] i_mem_addr,
   input wire logic i_flash_rd,
   input wire logic [11:0] i_flash_waddr,
   output logic [7:0] o_mem_rdata,
   output logic [15:0] o_flash_rdata
);
   logic [7:0] idle_r = 8'h00;
   // Idle buses change every cycle, so a stale sample can never pass for an answer.
   always @(posedge i_core_clk) idle_r <= idle_r + 8'h5b;
   assign o_mem_rdata = i_mem_req ? (i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'ha5) : idle_r;
   assign o_flash_rdata = i_flash_rd ? {~i_flash_waddr[3:0], i_flash_waddr} : {idle_r, ~idle_r};
endmodule // mml_mem_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the memory access controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic i_core_clk, i_nrst, i_clk_en, i_cpu_req, i_cpu_we, i_cpu_fetch, i_pmr_req;
   logic i_dbg_req, i_dbg_we, i_dbg_fuse_wr, i_dbg_erase;
   logic [15:0] i_cpu_addr, i_pmr_addr, i_dbg_addr, i_flash_rdata, o_mem_addr, o_pmr_rdata;
   logic [15:0] o_stack_reset, a;
   logic [7:0] i_cpu_wdata, i_dbg_wdata, i_lock_store, i_mem_rdata, o_mem_wdata, o_cpu_rdata;
   logic [7:0] o_dbg_rdata, o_memory_lock_key, got_data, lk, seen_wd;
   logic [71:0] i_fuse_store, o_cfg_regs, f;
   logic [11:0] o_flash_waddr;
   logic [2:0] o_mem_region, seen_reg;
   logic o_mem_req, o_mem_we, o_flash_rd, o_fuse_prog, o_erase_go, o_cpu_ack, o_cpu_fault;
   logic o_dbg_ack, o_dbg_blocked, o_locked, o_cfg_valid, seen_req, seen_we, seen_er;
   logic got_flt, got_blk, seen_fp;
   logic [15:0] los [4];
   logic [2:0] rgs [4];
   logic [18:0] cases [8];
   int errors, n_tests, i;

   mml_access_ctrl dut (.i_core_clk, .i_nrst, .i_clk_en, .i_cpu_req, .i_cpu_we, .i_cpu_fetch,
      .i_cpu_addr, .i_cpu_wdata, .i_pmr_req, .i_pmr_addr, .i_dbg_req, .i_dbg_we, .i_dbg_fuse_wr,
      .i_dbg_erase, .i_dbg_addr, .i_dbg_wdata, .i_fuse_store, .i_lock_store, .i_mem_rdata,
      .i_flash_rdata, .o_mem_req, .o_mem_we, .o_mem_region, .o_mem_addr, .o_mem_wdata,
      .o_flash_rd, .o_flash_waddr, .o_fuse_prog, .o_erase_go, .o_cpu_ack, .o_cpu_fault,
      .o_cpu_rdata, .o_pmr_rdata, .o_dbg_ack, .o_dbg_rdata, .o_dbg_blocked, .o_locked,
      .o_memory_lock_key, .o_cfg_valid, .o_cfg_regs, .o_stack_reset);

   mml_mem_model mem (.i_core_clk, .i_mem_req(o_mem_req), .i_mem_addr(o_mem_addr),
      .i_flash_rd(o_flash_rd), .i_flash_waddr(o_flash_waddr), .o_mem_rdata(i_mem_rdata),
      .o_flash_rdata(i_flash_rdata));

   function automatic logic [7:0] mdat(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'ha5;
   endfunction

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic do_reset(input logic [7:0] key);
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      i_lock_store <= key;
      repeat (12) @(posedge i_core_clk);
      chk(o_locked, 1'b1);
      i_nrst <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      #1;
      chk(o_cfg_valid, 1'b1);
      chk(o_cfg_regs, i_fuse_store);
      chk(o_locked, key !== mml_pkg::LOCK_KEY_OPEN);
      chk(o_memory_lock_key, key);
      chk(o_stack_reset, mml_pkg::STACK_TOP);
   endtask

   // One request pulse; the answer is watched for a bounded number of cycles.
   task automatic xfer(input bit d, input bit we, input bit fx, input bit er,
                       input logic [15:0] ad, input logic [7:0] wd);
      int k;
      @(posedge i_core_clk);
      i_dbg_req <= d;
      i_cpu_req <= !d;
      i_dbg_we <= we;
      i_cpu_we <= we;
      i_dbg_fuse_wr <= fx & d;
      i_cpu_fetch <= fx & !d;
      i_dbg_erase <= er;
      i_dbg_addr <= ad;
      i_cpu_addr <= ad;
      i_dbg_wdata <= wd;
      i_cpu_wdata <= wd;
      @(posedge i_core_clk);
      i_dbg_req <= 1'b0;
      i_cpu_req <= 1'b0;
      i_dbg_erase <= 1'b0;
      seen_req = 1'b0;
      seen_er = 1'b0;
      seen_fp = 1'b0;
      for (k = 0; k < 5; k++) begin
         #1;
         seen_er = seen_er | o_erase_go;
         seen_fp = seen_fp | o_fuse_prog;
         if (o_mem_req === 1'b1) begin
            seen_req = 1'b1;
            seen_we = o_mem_we;
            seen_reg = o_mem_region;
            seen_wd = o_mem_wdata;
         end
         if ((o_cpu_ack | o_dbg_ack) === 1'b1) begin
            got_data = d ? o_dbg_rdata : o_cpu_rdata;
            got_flt = o_cpu_fault;
            got_blk = o_dbg_blocked;
            break;
         end
         @(posedge i_core_clk);
      end
      chk(k, 1);
   endtask

   task automatic run_mix(input bit locked);
      int r;
      for (i = 0; i < 24; i++) begin
         r = $urandom % 4;
         a = los[r] + 16'($urandom % 64);
         xfer(i[0], i[1], 1'b0, 1'b0, a, 8'($urandom));
         if (i[0] && locked) begin
            chk({seen_req, got_blk, got_data}, {2'b01, mml_pkg::BLOCKED_DATA});
         end else begin
            chk({seen_req, seen_we, seen_reg, got_blk}, {1'b1, i[1], rgs[r], 1'b0});
            if (!i[1])
               chk(got_data, mdat(a));
         end
      end
   endtask

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   initial begin
      repeat (20000) @(posedge i_core_clk);
      errors++;
      test_done();
   end

   initial begin
      {i_nrst, i_cpu_req, i_cpu_we, i_cpu_fetch, i_pmr_req, i_dbg_req, i_dbg_we} = '0;
      {i_dbg_fuse_wr, i_dbg_erase, i_cpu_addr, i_pmr_addr, i_dbg_addr} = '0;
      {i_cpu_wdata, i_dbg_wdata, i_lock_store} = '0;
      i_clk_en = 1'b1;
      errors = 0;
      n_tests = 0;
      void'($urandom(32'h030c));
      i_fuse_store = 72'({$urandom, $urandom, $urandom});
      los = '{mml_pkg::IO_SC_LO, mml_pkg::EE_LO, mml_pkg::SRAM_LO, mml_pkg::USER_LO};
      rgs = '{3'h1, 3'h5, 3'h6, 3'h4};
      cases[0] = {3'b101, mml_pkg::SRAM_LO};
      cases[1] = {3'b100, mml_pkg::FLASH_DS_LO};
      cases[2] = {3'b000, 16'hffff};
      cases[3] = {3'b011, mml_pkg::SIG_LO};
      cases[4] = {3'b011, mml_pkg::FUSE_LO};
      cases[5] = {3'b011, mml_pkg::LOCK_LO};
      cases[6] = {3'b000, mml_pkg::FUSE_HI};
      cases[7] = {3'b000, mml_pkg::SIG_HI};
      do_reset(mml_pkg::LOCK_KEY_OPEN);
      run_mix(1'b0);
      for (i = 0; i < 8; i++) begin
         xfer(1'b0, cases[i][17], cases[i][18], 1'b0, cases[i][15:0], 8'h77);
         chk(got_flt, cases[i][16]);
      end
      for (i = 0; i < 6; i++) begin
         a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0fff : 16'($urandom % 4096);
         @(posedge i_core_clk);
         i_pmr_req <= 1'b1;
         i_pmr_addr <= a;
         @(posedge i_core_clk);
         i_pmr_req <= 1'b0;
         repeat (2) @(posedge i_core_clk);
         #1;
         chk(o_pmr_rdata, {~a[3:0], a[11:0]});
      end
      xfer(1'b1, 1'b1, 1'b1, 1'b0, mml_pkg::FUSE_LO + 16'h0003, 8'hff);
      chk({seen_req, seen_fp, seen_wd, got_blk}, {2'b11, 8'hff, 1'b0});
      f = i_fuse_store;
      i_fuse_store <= ~f;
      repeat (4) @(posedge i_core_clk);
      #1;
      chk(o_cfg_regs, f);
      lk = 8'($urandom);
      if (lk === mml_pkg::LOCK_KEY_OPEN)
         lk = 8'hc4;
      do_reset(lk);
      run_mix(1'b1);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, mml_pkg::FLASH_DS_LO, 8'h00);
      chk({seen_req, got_blk, got_data}, {2'b01, mml_pkg::BLOCKED_DATA});
      xfer(1'b1, 1'b0, 1'b0, 1'b0, mml_pkg::FUSE_LO, 8'h00);
      chk({seen_req, got_blk, got_data}, {2'b01, mml_pkg::BLOCKED_DATA});
      xfer(1'b1, 1'b1, 1'b1, 1'b0, mml_pkg::USER_LO + 16'h0003, 8'h5a);
      chk({seen_req, seen_we, seen_reg, seen_fp, seen_wd, got_blk},
          {2'b11, 3'h4, 1'b1, 8'h5a, 1'b0});
      xfer(1'b1, 1'b0, 1'b0, 1'b0, mml_pkg::USER_LO + 16'h0003, 8'h00);
      chk({seen_req, got_blk}, 2'b01);
      xfer(1'b1, 1'b1, 1'b1, 1'b0, mml_pkg::FUSE_LO, 8'hff);
      chk({seen_req, seen_fp, got_blk}, 3'b001);
      xfer(1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 8'h00);
      repeat (2) @(posedge i_core_clk);
      #1;
      chk({seen_er, o_locked, o_memory_lock_key}, {2'b10, mml_pkg::LOCK_KEY_OPEN});
      xfer(1'b1, 1'b0, 1'b0, 1'b0, mml_pkg::SRAM_LO, 8'h00);
      chk({got_blk, got_data}, {1'b0, mdat(mml_pkg::SRAM_LO)});
      test_done();
   end
endmodule // tb_top
`default_nettype wire

// file: hw/mml_access_ctrl.sv
// Memory map decode, access control (the lock gates the debug port only) and fuse loading for CPU and debug port.
`timescale 1ns/10ps
`default_nettype none
module mml_access_ctrl (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   // CPU data-space request.
   input wire logic i_cpu_req,
   input wire logic i_cpu_we,
   input wire logic i_cpu_fetch,
   input wire logic [15:0] i_cpu_addr,
   input wire logic [7:0] i_cpu_wdata,
   // CPU program-memory read, word address.
   input wire logic i_pmr_req,
   input wire logic [15:0] i_pmr_addr,
   // Debug-port request.
   input wire logic i_dbg_req,
   input wire logic i_dbg_we,
   input wire logic i_dbg_fuse_wr,
   input wire logic i_dbg_erase,
   input wire logic [15:0] i_dbg_addr,
   input wire logic [7:0] i_dbg_wdata,
   // Stored nonvolatile data: fuses and memory read returns.
   input wire logic [71:0] i_fuse_store,
   input wire logic [7:0] i_lock_store,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [15:0] i_flash_rdata,
   // Memory side.
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [2:0] o_mem_region,
   output logic [15:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   output logic o_flash_rd,
   output logic [11:0] o_flash_waddr,
   output logic o_fuse_prog,
   output logic o_erase_go,
   // Answers.
   output logic o_cpu_ack,
   output logic o_cpu_fault,
   output logic [7:0] o_cpu_rdata,
   output logic [15:0] o_pmr_rdata,
   output logic o_dbg_ack,
   output logic [7:0] o_dbg_rdata,
   output logic o_dbg_blocked,
   // Lock and configuration state.
   output logic o_locked,
   output logic [7:0] o_memory_lock_key,
   output logic o_cfg_valid,
   output logic [71:0] o_cfg_regs,
   output logic [15:0] o_stack_reset
);
   mml_pkg::mml_region_t cpu_reg, dbg_reg;
   logic cpu_sc_io, dbg_sc_io, cpu_lock_area;
   logic [7:0] key_r;
   logic locked_r;
   logic [3:0] boot_cnt_r;
   logic cfg_valid_r;
   logic [71:0] cfg_r;
   logic started_r;
   logic cpu_pend_r, dbg_pend_r, pmr_pend_r, dbg_blk_r;
   logic [7:0] cpu_rd_r, dbg_rd_r;
   logic [15:0] pmr_rd_r;
   logic mem_req_r, mem_we_r, flash_rd_r, fuse_prog_r, erase_r, cpu_fault_r;
   logic [2:0] mem_region_r;
   logic [15:0] mem_addr_r;
   logic [7:0] mem_wdata_r;
   logic [11:0] flash_waddr_r;
   logic [15:0] stack_r;

   mml_decode u_cpu_dec (
      .i_addr(i_cpu_addr),
      .o_region(cpu_reg),
      .o_single_cycle_io(cpu_sc_io),
      .o_lock_area(cpu_lock_area)
   );
   mml_decode u_dbg_dec (
      .i_addr(i_dbg_addr),
      .o_region(dbg_reg),
      .o_single_cycle_io(dbg_sc_io),
      .o_lock_area()
   );

   // Access permission terms.
   wire cpu_fetch_bad = i_cpu_fetch && (cpu_reg != mml_pkg::MML_REG_FLASH);
   wire cpu_nv_ro = (cpu_reg == mml_pkg::MML_REG_FUSE) || (cpu_reg == mml_pkg::MML_REG_SIG);
   wire cpu_wr_bad = i_cpu_we && cpu_nv_ro;
   wire cpu_ok = !cpu_fetch_bad && !cpu_wr_bad && (cpu_reg != mml_pkg::MML_REG_NONE);
   wire dbg_sig_wr = i_dbg_we && (dbg_reg == mml_pkg::MML_REG_SIG);
   wire dbg_user_wr = i_dbg_fuse_wr && (dbg_reg == mml_pkg::MML_REG_USER);
   wire dbg_fuse_wr = i_dbg_fuse_wr && (dbg_reg == mml_pkg::MML_REG_FUSE);
   // Locked: only the fuse-write into the settings page gets through.
   wire dbg_ok = locked_r ? dbg_user_wr :
                 (!dbg_sig_wr && (dbg_reg != mml_pkg::MML_REG_NONE));
   wire dbg_rd = i_dbg_req && !i_dbg_we && !i_dbg_fuse_wr;
   wire dbg_go = i_dbg_req && dbg_ok && !i_dbg_erase;
   wire cpu_go = i_cpu_req && cpu_ok && !dbg_go;
   wire mem_go = dbg_go || cpu_go;
   wire fuse_prog_nxt = dbg_go && (dbg_fuse_wr || (i_dbg_fuse_wr && dbg_user_wr));
   wire [11:0] pmr_waddr = i_pmr_addr[mml_pkg::FLASH_WAW-1:0];
   wire [11:0] ds_waddr = i_cpu_addr[mml_pkg::FLASH_WAW:1];
   wire key_open = (i_lock_store == mml_pkg::LOCK_KEY_OPEN);
   wire boot_done = (boot_cnt_r == mml_pkg::STARTUP_CYC);

   // Lock key and fuse images are captured once at the end of start-up, so later
   // programming only shows up after the next reset, except a debug erase, which opens the lock key at once.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         boot_cnt_r <= 4'h0;
         started_r <= 1'b0;
         cfg_valid_r <= 1'b0;
         key_r <= mml_pkg::LOCK_KEY_RST;
         locked_r <= 1'b1;
         cfg_r <= {mml_pkg::FUSE_CNT{mml_pkg::FUSE_RST}};
         stack_r <= mml_pkg::STACK_TOP;
      end else if (i_clk_en) begin
         if (!boot_done) begin
            boot_cnt_r <= boot_cnt_r + 4'h1;
         end
         if (boot_done && !started_r) begin
            started_r <= 1'b1;
            cfg_valid_r <= 1'b1;
            cfg_r <= i_fuse_store;
            key_r <= i_lock_store;
            locked_r <= !key_open;
         end else if (i_dbg_req && i_dbg_erase) begin
            locked_r <= 1'b0;
            key_r <= mml_pkg::LOCK_KEY_OPEN;
         end
      end
   end

   // Request path: one registered cycle to the memories and one more back.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mem_req_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_region_r <= 3'h0;
         mem_addr_r <= 16'h0000;
         mem_wdata_r <= 8'h00;
         flash_rd_r <= 1'b0;
         flash_waddr_r <= 12'h000;
         fuse_prog_r <= 1'b0;
         erase_r <= 1'b0;
         cpu_pend_r <= 1'b0;
         dbg_pend_r <= 1'b0;
         pmr_pend_r <= 1'b0;
         dbg_blk_r <= 1'b0;
         cpu_fault_r <= 1'b0;
      end else if (i_clk_en) begin
         mem_req_r <= mem_go && started_r;
         mem_we_r <= dbg_go ? (i_dbg_we || i_dbg_fuse_wr) : i_cpu_we;
         mem_region_r <= dbg_go ? dbg_reg : cpu_reg;
         mem_addr_r <= dbg_go ? i_dbg_addr : i_cpu_addr;
         mem_wdata_r <= dbg_go ? i_dbg_wdata : i_cpu_wdata;
         flash_rd_r <= i_pmr_req && started_r;
         flash_waddr_r <= i_pmr_req ? pmr_waddr : ds_waddr;
         fuse_prog_r <= fuse_prog_nxt && started_r;
         // Erase wipes application memories; the settings page is not touched.
         erase_r <= i_dbg_req && i_dbg_erase && started_r;
         cpu_pend_r <= i_cpu_req && started_r && !dbg_go;
         cpu_fault_r <= i_cpu_req && started_r && !cpu_ok;
         pmr_pend_r <= i_pmr_req && started_r;
         dbg_pend_r <= i_dbg_req && started_r;
         dbg_blk_r <= i_dbg_req && started_r && !dbg_ok && !i_dbg_erase;
      end
   end

   // Read data; a blocked debug read still acknowledges but returns a fixed value.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cpu_rd_r <= 8'h00;
         dbg_rd_r <= 8'h00;
         pmr_rd_r <= 16'h0000;
      end else if (i_clk_en) begin
         if (cpu_pend_r) begin
            cpu_rd_r <= cpu_fault_r ? mml_pkg::BLOCKED_DATA : i_mem_rdata;
         end
         if (pmr_pend_r) begin
            pmr_rd_r <= i_flash_rdata;
         end
         if (dbg_pend_r) begin
            dbg_rd_r <= dbg_blk_r ? mml_pkg::BLOCKED_DATA : i_mem_rdata;
         end
      end
   end

   logic cpu_ack_r, dbg_ack_r, dbg_blocked_r, cpu_flt_ack_r;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cpu_ack_r <= 1'b0;
         dbg_ack_r <= 1'b0;
         dbg_blocked_r <= 1'b0;
         cpu_flt_ack_r <= 1'b0;
      end else if (i_clk_en) begin
         cpu_ack_r <= cpu_pend_r;
         dbg_ack_r <= dbg_pend_r;
         dbg_blocked_r <= dbg_pend_r && dbg_blk_r;
         // The fault flag is re-timed so that it stands with the acknowledge it belongs to.
         cpu_flt_ack_r <= cpu_pend_r && cpu_fault_r;
      end
   end

   assign o_mem_req = mem_req_r;
   assign o_mem_we = mem_we_r;
   assign o_mem_region = mem_region_r;
   assign o_mem_addr = mem_addr_r;
   assign o_mem_wdata = mem_wdata_r;
   assign o_flash_rd = flash_rd_r;
   assign o_flash_waddr = flash_waddr_r;
   assign o_fuse_prog = fuse_prog_r;
   assign o_erase_go = erase_r;
   assign o_cpu_ack = cpu_ack_r;
   assign o_cpu_fault = cpu_flt_ack_r;
   assign o_cpu_rdata = cpu_rd_r;
   assign o_pmr_rdata = pmr_rd_r;
   assign o_dbg_ack = dbg_ack_r;
   assign o_dbg_rdata = dbg_rd_r;
   assign o_dbg_blocked = dbg_blocked_r;
   assign o_locked = locked_r;
   assign o_memory_lock_key = key_r;
   assign o_cfg_valid = cfg_valid_r;
   assign o_cfg_regs = cfg_r;
   assign o_stack_reset = stack_r;

   // Checks.
   sequence s_boot_end;
      boot_done && !started_r && i_clk_en;
   endsequence
   // A locked debug read is taken, then two enabled edges bring its answer out.
   sequence s_locked_dbg_read;
      i_clk_en && locked_r && started_r && dbg_rd && !i_dbg_erase ##1 i_clk_en[*2];
   endsequence
   sequence s_locked_dbg_other;
      i_clk_en && started_r && locked_r && i_dbg_req && !i_cpu_req && !i_dbg_erase
      && !(i_dbg_fuse_wr && (dbg_reg == mml_pkg::MML_REG_USER));
   endsequence
   chk_key_lock_state: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      s_boot_end |=> (locked_r == ($past(i_lock_store) != mml_pkg::LOCK_KEY_OPEN)))
      else $error("lock state does not follow key");
   chk_fuse_load_copy: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      s_boot_end |=> (cfg_r == $past(i_fuse_store)) && cfg_valid_r)
      else $error("fuse image not loaded at start-up end");
   chk_cfg_hold_stable: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      started_r && $past(started_r) |-> $stable(cfg_r))
      else $error("configuration changed without reset");
   chk_dbg_read_blocked: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      s_locked_dbg_read |-> o_dbg_ack && o_dbg_rdata == 8'h00)
      else $error("locked debug read leaked data");
   chk_user_write_locked: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_clk_en && started_r && locked_r && i_dbg_req && i_dbg_fuse_wr && !i_dbg_erase
      && dbg_reg == mml_pkg::MML_REG_USER |=> o_mem_req && o_mem_we)
      else $error("locked settings write refused");
   chk_locked_no_bus: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      s_locked_dbg_other |=> !o_mem_req && !o_fuse_prog && dbg_blk_r)
      else $error("locked debug port reached bus");
   chk_cpu_lock_free: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_clk_en && started_r && i_cpu_req && !i_dbg_req && !i_cpu_we && !i_cpu_fetch
      && cpu_reg == mml_pkg::MML_REG_SRAM |=> o_mem_req && !cpu_fault_r)
      else $error("cpu access restricted");
   chk_sig_never_wr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_mem_req && o_mem_we |-> o_mem_region != 3'(mml_pkg::MML_REG_SIG))
      else $error("signature row written");
   chk_sram_no_fetch: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_clk_en && started_r && i_cpu_req && i_cpu_fetch && cpu_reg == mml_pkg::MML_REG_SRAM
      |=> cpu_fault_r)
      else $error("fetch from sram allowed");
   chk_erase_unlocks: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_clk_en && started_r && i_dbg_req && i_dbg_erase |=> !locked_r && erase_r)
      else $error("erase did not unlock");
   chk_ee_window: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_cpu_addr >= 16'h1400 && i_cpu_addr <= 16'h14ff) |-> cpu_reg == mml_pkg::MML_REG_EE)
      else $error("eeprom window misdecoded");
   chk_sc_io_decode: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (!cpu_sc_io || cpu_reg == mml_pkg::MML_REG_IO)
      && (!dbg_sc_io || dbg_reg == mml_pkg::MML_REG_IO))
      else $error("single-cycle register window misdecoded");
   chk_lock_key_ro: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_clk_en && started_r && i_cpu_req && i_cpu_we && cpu_lock_area && !i_dbg_req
      |=> cpu_fault_r && !o_mem_req)
      else $error("cpu write to lock key allowed");
   chk_fault_with_ack: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_cpu_fault |-> o_cpu_ack && o_cpu_rdata == mml_pkg::BLOCKED_DATA)
      else $error("cpu fault out of step with acknowledge");
   chk_blocked_answer: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_dbg_blocked |-> o_dbg_ack && o_dbg_rdata == mml_pkg::BLOCKED_DATA)
      else $error("blocked debug answer carries data");
endmodule // mml_access_ctrl
`default_nettype wire

// file: hw/mml_decode.sv
// Data-space address decoder shared by the CPU and debug-port paths.
`timescale 1ns/10ps
`default_nettype none
module mml_decode (
   input wire logic [15:0] i_addr,
   output var mml_pkg::mml_region_t o_region,
   output logic o_single_cycle_io,
   output logic o_lock_area
);
   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction
   assign o_single_cycle_io = in_rng(i_addr, mml_pkg::IO_SC_LO, mml_pkg::IO_SC_HI);
   assign o_lock_area = in_rng(i_addr, mml_pkg::LOCK_LO, mml_pkg::LOCK_HI);
   assign o_region =
      (i_addr >= mml_pkg::FLASH_DS_LO) ? mml_pkg::MML_REG_FLASH :
      in_rng(i_addr, mml_pkg::SRAM_LO, mml_pkg::SRAM_HI) ? mml_pkg::MML_REG_SRAM :
      in_rng(i_addr, mml_pkg::EE_LO, mml_pkg::EE_HI) ? mml_pkg::MML_REG_EE :
      in_rng(i_addr, mml_pkg::USER_LO, mml_pkg::USER_HI) ? mml_pkg::MML_REG_USER :
      in_rng(i_addr, mml_pkg::FUSE_LO, mml_pkg::LOCK_HI) ? mml_pkg::MML_REG_FUSE :
      in_rng(i_addr, mml_pkg::SIG_LO, mml_pkg::SIG_HI) ? mml_pkg::MML_REG_SIG :
      in_rng(i_addr, mml_pkg::IO_SC_LO, mml_pkg::IO_HI) ? mml_pkg::MML_REG_IO :
      mml_pkg::MML_REG_NONE;
endmodule // mml_decode
`default_nettype wire

// file: hw/mml_pkg.sv
// Package with address map, lock key and timing constants for the memory access control block.
package mml_pkg;
   // Data-space windows.
   localparam logic [15:0] IO_SC_LO = 16'h0000;
   localparam logic [15:0] IO_SC_HI = 16'h003f;
   localparam logic [15:0] IO_HI = 16'h107f;
   localparam logic [15:0] SIG_LO = 16'h1100;
   localparam logic [15:0] SIG_HI = 16'h11ff;
   localparam logic [15:0] FUSE_LO = 16'h1280;
   localparam logic [15:0] FUSE_HI = 16'h1289;
   localparam logic [15:0] LOCK_LO = 16'h128a;
   localparam logic [15:0] LOCK_HI = 16'h12ff;
   localparam logic [15:0] USER_LO = 16'h1300;
   localparam logic [15:0] USER_HI = 16'h137f;
   localparam logic [15:0] EE_LO = 16'h1400;
   localparam logic [15:0] EE_HI = 16'h14ff;
   localparam logic [15:0] SRAM_LO = 16'h3800;
   localparam logic [15:0] SRAM_HI = 16'h3fff;
   localparam logic [15:0] FLASH_DS_LO = 16'h8000;
   localparam logic [15:0] FLASH_CS_LO = 16'h0000;
   // Flash holds 4K sixteen-bit words.
   localparam int FLASH_WORDS = 4096;
   localparam int FLASH_WAW = 12;
   localparam int FUSE_CNT = 9;
   localparam logic [3:0] LOCK_KEY_OFS = 4'h0;
   localparam logic [7:0] LOCK_KEY_OPEN = 8'hc5;
   localparam logic [7:0] LOCK_KEY_RST = 8'h00;
   localparam logic [7:0] BLOCKED_DATA = 8'h00;
   localparam logic [7:0] FUSE_RST = 8'h00;
   localparam logic [15:0] STACK_TOP = SRAM_HI;
   // Cycles from reset release to the end of start-up.
   localparam logic [3:0] STARTUP_CYC = 4'h4;
   typedef enum logic [2:0] {
      MML_REG_NONE, MML_REG_IO, MML_REG_SIG, MML_REG_FUSE, MML_REG_USER, MML_REG_EE,
      MML_REG_SRAM, MML_REG_FLASH
   } mml_region_t;
endpackage
